// [ccr_pkg.sv]
// shared constants and types for the calendar clock register block
package ccr_pkg;
  // register indices; byte address is four times the index
  localparam logic [13:0] IDX_UNLOCK   = 14'h20a0;
  localparam logic [13:0] IDX_OSC_TRIM = 14'h2504;
  localparam logic [13:0] IDX_CTRL     = 14'h2890;
  localparam logic [13:0] IDX_SUBSEC   = 14'h2892;
  localparam logic [13:0] IDX_SEC      = 14'h2893;
  localparam logic [13:0] IDX_MIN      = 14'h2894;
  localparam logic [13:0] IDX_HOUR     = 14'h2895;
  localparam logic [13:0] IDX_WDAY     = 14'h2896;
  localparam logic [13:0] IDX_MDAY     = 14'h2897;
  localparam logic [13:0] IDX_MONTH    = 14'h2898;
  localparam logic [13:0] IDX_YEAR     = 14'h2899;
  localparam logic [13:0] IDX_ADJ_HI   = 14'h289b;
  localparam logic [13:0] IDX_ADJ_MID  = 14'h289c;
  localparam logic [13:0] IDX_ADJ_LO   = 14'h289d;
  localparam logic [13:0] IDX_ALM_MIN  = 14'h289e;
  localparam logic [13:0] IDX_ALM_HOUR = 14'h289f;
  localparam logic [13:0] IDX_IRQ_STS  = 14'h28a0;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h28a1;
  // control register fields
  localparam int CTRL_WR_BIT   = 7;
  localparam int CTRL_RD_BIT   = 6;
  localparam int CTRL_FAIL_BIT = 4;
  // interrupt status fields
  localparam int IRQ_ALARM  = 0;
  localparam int IRQ_SECOND = 1;
  localparam int IRQ_FAULT  = 2;
  localparam int IRQ_W      = 3;
  // reset values
  localparam logic [6:0] OSC_TRIM_RST = 7'h40;
  localparam logic [2:0] ADJ_HI_RST   = 3'h4;
  // calendar limits
  localparam logic [5:0] SEC_MAX   = 6'd59;
  localparam logic [4:0] HOUR_MAX  = 5'd23;
  localparam logic [2:0] WDAY_MAX  = 3'd7;
  localparam logic [3:0] MONTH_MAX = 4'd12;
  localparam logic [7:0] YEAR_MAX  = 8'd99;
  localparam logic [3:0] FEB       = 4'd2;
  // timing: slow tick near 1 kHz, sub-second step 1/128 s
  localparam int CLK_HZ        = 100000000;
  localparam int TICK_HZ       = 1000;
  localparam int TICK_DIV_DFLT = CLK_HZ / TICK_HZ;
  localparam logic [9:0] TICKS_PER_SEC = 10'(TICK_HZ);
  localparam int SUBSEC_STEPS  = 128;

  typedef struct packed {
    logic [5:0] sec;
    logic [5:0] min;
    logic [4:0] hour;
    logic [2:0] wday;
    logic [4:0] mday;
    logic [3:0] month;
    logic [7:0] year;
  } ccr_cal_t;

  localparam ccr_cal_t CAL_RST = '{6'h00, 6'h00, 5'h00, 3'h1, 5'h01, 4'h1, 8'h00};

  typedef struct packed {
    logic [15:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } ccr_apb_req_t;
endpackage

// [ccr_calendar_clock_registers.sv]
// calendar clock registers: counters, shadow, alarm, trims, apb slave
// What this block does
// [R1] count fault sets error flag; writing zero clears
// [R2] read freeze holds shadow; bit reads frozen state
// [R3] write freeze clear loads shadow at tick
// [R4] write freeze reads one until load happens
// [R5] read-only 8-bit sub-second count, 1/128 s
// [R6] alarm when minutes and hours match targets
// [R7] sec/min 0-59, hours 0-23, carry upward
// [R8] weekday 1-7, date 1-31, month 1-12, year 0-99
// [R9] year 00 and multiples of 4 leap
// [R10] software unlocks before each calendar field write
// [R11] calendar fields are software readable and writable
// [R12] coarse and fine adjust form 19-bit value
// [R13] software keeps coarse adjust within legal range
// [R14] 7-bit analog trim, resets to 0x40
// [R15] shadow tracks live time while not frozen
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module ccr_calendar_clock_registers #(
  parameter int TICK_DIV = ccr_pkg::TICK_DIV_DFLT
) (
  input  wire logic                 clock_i,
  input  wire logic                 rst_i,
  input  wire ccr_pkg::ccr_apb_req_t apb_i,
  output logic                      pready_o,
  output logic [31:0]               prdata_o,
  output logic                      pslverr_o,
  input  wire logic                 count_fault_i,
  output logic [18:0]               freq_adjust_o,
  output logic [6:0]                osc_trim_o,
  output logic                      irq_o
);
  import ccr_pkg::*;

  // ************************************************************
  // helper functions
  // ************************************************************

  // days in a month; year 00 counts as leap too
  function automatic logic [4:0] month_days(input logic [3:0] m, input logic [7:0] y);
    logic [4:0] d;
    d = 5'd31;
    if (m == FEB)
      d = (y[1:0] == 2'b00) ? 5'd29 : 5'd28; // R9
    else if (m == 4'd4 || m == 4'd6 || m == 4'd9 || m == 4'd11)
      d = 5'd30;
    return d;
  endfunction

  // advance calendar by one second with carry into higher fields
  function automatic ccr_cal_t cal_inc(input ccr_cal_t c);
    ccr_cal_t n;
    n = c;
    if (c.sec < SEC_MAX) // R7
      n.sec = c.sec + 6'd1;
    else
    begin
      n.sec = 6'd0;
      if (c.min < SEC_MAX)
        n.min = c.min + 6'd1;
      else
      begin
        n.min = 6'd0;
        if (c.hour < HOUR_MAX)
          n.hour = c.hour + 5'd1;
        else
        begin
          n.hour = 5'd0;
          n.wday = (c.wday >= WDAY_MAX) ? 3'd1 : c.wday + 3'd1; // R8
          if (c.mday < month_days(c.month, c.year))
            n.mday = c.mday + 5'd1;
          else
          begin
            n.mday = 5'd1;
            if (c.month < MONTH_MAX)
              n.month = c.month + 4'd1;
            else
            begin
              n.month = 4'd1;
              n.year  = (c.year >= YEAR_MAX) ? 8'd0 : c.year + 8'd1;
            end
          end
        end
      end
    end
    return n;
  endfunction

  // ************************************************************
  // apb decode
  // ************************************************************

  logic [13:0] idx;
  logic        setup;
  logic        wr_acc;
  logic        mapped;

  assign idx    = apb_i.paddr[15:2];
  assign setup  = apb_i.psel && !apb_i.penable;
  assign wr_acc = apb_i.psel && apb_i.penable && apb_i.pwrite;
  // slave never inserts wait states
  assign pready_o = 1'b1;

  // address map check
  always_comb
  begin
    unique case (idx)
      IDX_UNLOCK, IDX_OSC_TRIM, IDX_CTRL, IDX_SUBSEC, IDX_SEC, IDX_MIN,
      IDX_HOUR, IDX_WDAY, IDX_MDAY, IDX_MONTH, IDX_YEAR, IDX_ADJ_HI,
      IDX_ADJ_MID, IDX_ADJ_LO, IDX_ALM_MIN, IDX_ALM_HOUR, IDX_IRQ_STS,
      IDX_IRQ_MASK: mapped = 1'b1;
      default:      mapped = 1'b0;
    endcase
  end

  // ************************************************************
  // slow tick and sub-second counter
  // ************************************************************

  logic [16:0] div_q;
  logic        tick;
  logic [9:0]  ms_q;
  logic [7:0]  subsec_q;
  logic        sec_edge;
  logic        pend_q;

  assign tick     = div_q == 17'(TICK_DIV - 1);
  assign sec_edge = tick && !pend_q && ms_q == TICKS_PER_SEC - 10'd1;

  // clock divider for the ~1 kHz counter clock
  always_ff @(posedge clock_i)
  begin
    if (rst_i || tick)
      div_q <= 17'h0;
    else
      div_q <= div_q + 17'h1;
  end

  // ticks within the second; restart after a software load
  always_ff @(posedge clock_i)
  begin
    if (rst_i || (tick && (pend_q || ms_q == TICKS_PER_SEC - 10'd1)))
      ms_q <= 10'h0;
    else if (tick)
      ms_q <= ms_q + 10'h1;
  end

  // remaining part of the second in 1/128 steps
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      subsec_q <= 8'h0;
    else
      subsec_q <= 8'((18'(TICKS_PER_SEC - 10'd1 - ms_q) * 18'(SUBSEC_STEPS))
                     / 18'(TICKS_PER_SEC)); // R5
  end

  // ************************************************************
  // control, unlock, shadow and live calendar
  // ************************************************************

  logic     wr_q;
  logic     rd_q;
  logic     fail_q;
  logic     unlock_q;
  logic     cal_wr;
  ccr_cal_t live_q;
  ccr_cal_t shadow_q;

  assign cal_wr = wr_acc && unlock_q && idx >= IDX_SEC && idx <= IDX_YEAR;

  // freeze bits; clearing write freeze arms the load
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end
    else if (wr_acc && idx == IDX_CTRL)
    begin
      wr_q <= apb_i.pwdata[CTRL_WR_BIT]; // R3
      rd_q <= apb_i.pwdata[CTRL_RD_BIT]; // R2
    end
  end

  // load pending from freeze release until the next tick
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      pend_q <= 1'b0;
    else if (wr_acc && idx == IDX_CTRL && wr_q && !apb_i.pwdata[CTRL_WR_BIT])
      pend_q <= 1'b1; // R3
    else if (tick)
      pend_q <= 1'b0; // R4
  end

  // count error flag; a fault in the clear cycle wins
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      fail_q <= 1'b0;
    else if (count_fault_i)
      fail_q <= 1'b1; // R1
    else if (wr_acc && idx == IDX_CTRL && !apb_i.pwdata[CTRL_FAIL_BIT])
      fail_q <= 1'b0; // R1
  end

  // unlock lasts only until the next write of any kind
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      unlock_q <= 1'b0;
    else if (wr_acc)
      unlock_q <= idx == IDX_UNLOCK; // R10
  end

  // shadow follows live unless frozen; software writes land here
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      shadow_q <= CAL_RST;
    else if (cal_wr)
    begin
      unique case (idx) // R11
        IDX_SEC:   shadow_q.sec   <= apb_i.pwdata[5:0];
        IDX_MIN:   shadow_q.min   <= apb_i.pwdata[5:0];
        IDX_HOUR:  shadow_q.hour  <= apb_i.pwdata[4:0];
        IDX_WDAY:  shadow_q.wday  <= apb_i.pwdata[2:0];
        IDX_MDAY:  shadow_q.mday  <= apb_i.pwdata[4:0];
        IDX_MONTH: shadow_q.month <= apb_i.pwdata[3:0];
        default:   shadow_q.year  <= apb_i.pwdata[7:0];
      endcase
    end
    else if (!rd_q && !wr_q && !pend_q)
      shadow_q <= live_q; // R15
  end

  // live counter: load from shadow or advance once per second
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      live_q <= CAL_RST;
    else if (tick && pend_q)
      live_q <= shadow_q; // R3
    else if (sec_edge)
      live_q <= cal_inc(live_q); // R7
  end

  // ************************************************************
  // trims, adjust and alarm targets
  // ************************************************************

  logic [6:0]  trim_q;
  logic [16:0] coarse_q;
  logic [1:0]  fine_q;
  logic [5:0]  alm_min_q;
  logic [4:0]  alm_hour_q;

  // plain read/write setting registers
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      trim_q     <= OSC_TRIM_RST; // R14
      coarse_q   <= {ADJ_HI_RST, 14'h0};
      fine_q     <= 2'h0;
      alm_min_q  <= 6'h0;
      alm_hour_q <= 5'h0;
    end
    else if (wr_acc)
    begin
      if (idx == IDX_OSC_TRIM)
        trim_q <= apb_i.pwdata[6:0]; // R14
      if (idx == IDX_ADJ_HI)
        coarse_q[16:14] <= apb_i.pwdata[2:0];
      if (idx == IDX_ADJ_MID)
        coarse_q[13:6] <= apb_i.pwdata[7:0];
      if (idx == IDX_ADJ_LO)
      begin
        coarse_q[5:0] <= apb_i.pwdata[7:2];
        fine_q        <= apb_i.pwdata[1:0];
      end
      if (idx == IDX_ALM_MIN)
        alm_min_q <= apb_i.pwdata[5:0];
      if (idx == IDX_ALM_HOUR)
        alm_hour_q <= apb_i.pwdata[4:0];
    end
  end

  // range is the software's duty; hardware passes the value on
  assign freq_adjust_o = {coarse_q, fine_q}; // R12 R13
  assign osc_trim_o    = trim_q;

  // ************************************************************
  // interrupt status and mask
  // ************************************************************

  logic               match;
  logic               match_q;
  logic               fault_q;
  logic [IRQ_W-1:0]   sts_q;
  logic [IRQ_W-1:0]   mask_q;
  logic [IRQ_W-1:0]   evt;

  assign match = live_q.min == alm_min_q && live_q.hour == alm_hour_q;
  assign evt   = {count_fault_i && !fault_q, sec_edge, match && !match_q}; // R6

  // edge memory so a lasting match fires once
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      match_q <= 1'b1;
      fault_q <= 1'b0;
    end
    else
    begin
      match_q <= match;
      fault_q <= count_fault_i;
    end
  end

  // sticky status, write one to clear; a new event wins
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      sts_q <= '0;
    else if (wr_acc && idx == IDX_IRQ_STS)
      sts_q <= (sts_q & ~apb_i.pwdata[IRQ_W-1:0]) | evt;
    else
      sts_q <= sts_q | evt; // R6
  end

  // interrupt enable mask
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      mask_q <= '0;
    else if (wr_acc && idx == IDX_IRQ_MASK)
      mask_q <= apb_i.pwdata[IRQ_W-1:0];
  end

  assign irq_o = |(sts_q & mask_q);

  // ************************************************************
  // read data and error response
  // ************************************************************

  logic [31:0] rdata;

  // calendar reads come from the shadow, never the live counter
  always_comb
  begin
    rdata = 32'h0;
    unique case (idx)
      IDX_OSC_TRIM: rdata[6:0] = trim_q;
      IDX_CTRL:
      begin
        rdata[CTRL_WR_BIT]   = wr_q || pend_q; // R4
        rdata[CTRL_RD_BIT]   = rd_q;           // R2
        rdata[CTRL_FAIL_BIT] = fail_q;         // R1
      end
      IDX_SUBSEC:   rdata[7:0] = subsec_q;
      IDX_SEC:      rdata[5:0] = shadow_q.sec;
      IDX_MIN:      rdata[5:0] = shadow_q.min;
      IDX_HOUR:     rdata[4:0] = shadow_q.hour;
      IDX_WDAY:     rdata[2:0] = shadow_q.wday;
      IDX_MDAY:     rdata[4:0] = shadow_q.mday;
      IDX_MONTH:    rdata[3:0] = shadow_q.month;
      IDX_YEAR:     rdata[7:0] = shadow_q.year;
      IDX_ADJ_HI:   rdata[2:0] = coarse_q[16:14];
      IDX_ADJ_MID:  rdata[7:0] = coarse_q[13:6];
      IDX_ADJ_LO:   rdata[7:0] = {coarse_q[5:0], fine_q};
      IDX_ALM_MIN:  rdata[5:0] = alm_min_q;
      IDX_ALM_HOUR: rdata[4:0] = alm_hour_q;
      IDX_IRQ_STS:  rdata[IRQ_W-1:0] = sts_q;
      IDX_IRQ_MASK: rdata[IRQ_W-1:0] = mask_q;
      default:      rdata = 32'h0;
    endcase
  end

  // answer sampled at setup, held through the access cycle
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      prdata_o  <= 32'h0;
      pslverr_o <= 1'b0;
    end
    else if (setup)
    begin
      prdata_o  <= apb_i.pwrite ? 32'h0 : rdata;
      pslverr_o <= !mapped;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************

  AST_FAIL_SET: assert property (@(posedge clock_i) disable iff (rst_i) // R1
    count_fault_i |=> fail_q)
    else $error("count error flag not set by fault");

  AST_FAIL_CLR: assert property (@(posedge clock_i) disable iff (rst_i) // R1
    wr_acc && idx == IDX_CTRL && !apb_i.pwdata[CTRL_FAIL_BIT] && !count_fault_i
    |=> !fail_q)
    else $error("count error flag not cleared by zero write");

  AST_RD_HOLD: assert property (@(posedge clock_i) disable iff (rst_i) // R2
    rd_q && !cal_wr |=> $stable(shadow_q))
    else $error("shadow moved while read frozen");

  AST_WR_LOAD: assert property (@(posedge clock_i) disable iff (rst_i) // R3
    tick && pend_q |=> live_q == $past(shadow_q) && !pend_q)
    else $error("shadow not loaded at tick");

  AST_WR_VIEW: assert property (@(posedge clock_i) disable iff (rst_i) // R4
    wr_acc && idx == IDX_CTRL && wr_q && !apb_i.pwdata[CTRL_WR_BIT]
    |=> pend_q && (wr_q || pend_q))
    else $error("write freeze released before load");

  // the bus view of the freeze bit must stay high while the load waits
  AST_WR_READ: assert property (@(posedge clock_i) disable iff (rst_i) // R4
    pend_q && idx == IDX_CTRL |-> rdata[CTRL_WR_BIT])
    else $error("write freeze read low while load pending");

  // a fresh second leaves nearly all of it: the top count of 127/128
  AST_SUBSEC: assert property (@(posedge clock_i) disable iff (rst_i) // R5
    tick && (pend_q || ms_q == TICKS_PER_SEC - 10'd1) |=> ##1 subsec_q == 8'd127)
    else $error("sub-second count not full at second start");

  AST_ALARM: assert property (@(posedge clock_i) disable iff (rst_i) // R6
    match && !match_q |=> sts_q[IRQ_ALARM])
    else $error("alarm match lost");

  AST_SEC_ROLL: assert property (@(posedge clock_i) disable iff (rst_i) // R7
    sec_edge && live_q.sec == SEC_MAX |=> live_q.sec == 6'd0)
    else $error("seconds did not roll over");

  AST_WDAY_WRAP: assert property (@(posedge clock_i) disable iff (rst_i) // R8
    sec_edge && live_q.sec == SEC_MAX && live_q.min == SEC_MAX
    && live_q.hour == HOUR_MAX && live_q.wday == WDAY_MAX |=> live_q.wday == 3'd1)
    else $error("weekday did not wrap to one");

  AST_LEAP: assert property (@(posedge clock_i) disable iff (rst_i) // R9
    sec_edge && live_q.sec == SEC_MAX && live_q.min == SEC_MAX
    && live_q.hour == HOUR_MAX && live_q.month == FEB && live_q.mday == 5'd28
    && live_q.year[1:0] == 2'b00 |=> live_q.mday == 5'd29)
    else $error("leap day skipped");

  AST_TRACK: assert property (@(posedge clock_i) disable iff (rst_i) // R15
    !rd_q && !wr_q && !pend_q && !cal_wr |=> shadow_q == $past(live_q))
    else $error("shadow not tracking live time");
endmodule

// [ccr_calendar_clock_registers_bench.sv]
// self-checking bench for the calendar clock register block
`timescale 1ns/1ps
module ccr_calendar_clock_registers_bench;
  import ccr_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  localparam int DIV = 10;
  logic         clock_i;
  logic         rst_i;
  ccr_apb_req_t apb_q;
  logic         pready_o;
  logic [31:0]  prdata_o;
  logic         pslverr_o;
  logic         count_fault_i;
  logic [18:0]  freq_adjust_o;
  logic [6:0]   osc_trim_o;
  logic         irq_o;
  logic         last_err;
  logic [15:0]  lfsr_q;
  int           n_mismatch;
  int           tests_run;
  logic [13:0]  fidx [7] = '{IDX_SEC, IDX_MIN, IDX_HOUR, IDX_WDAY, IDX_MDAY, IDX_MONTH, IDX_YEAR};
  logic [7:0]   fset [7] = '{8'h3a, 8'h3b, 8'h17, 8'h07, 8'h1c, 8'h02, 8'h04};
  logic [7:0]   fexp [7];

  // short tick divider so a second is 10000 cycles
  ccr_calendar_clock_registers #(.TICK_DIV(DIV)) u_dut (
    .clock_i       (clock_i),
    .rst_i         (rst_i),
    .apb_i         (apb_q),
    .pready_o      (pready_o),
    .prdata_o      (prdata_o),
    .pslverr_o     (pslverr_o),
    .count_fault_i (count_fault_i),
    .freq_adjust_o (freq_adjust_o),
    .osc_trim_o    (osc_trim_o),
    .irq_o         (irq_o)
  );

  // 100 mhz clock
  initial clock_i = 1'b0;
  always #5 clock_i = ~clock_i;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // february length follows the every-fourth-year leap scheme
  function automatic logic [4:0] month_days(input logic [3:0] m, input logic [7:0] y);
    if (m == FEB)
      return (y % 4 == 0) ? 5'd29 : 5'd28;
    if (m == 4'd4 || m == 4'd6 || m == 4'd9 || m == 4'd11)
      return 5'd30;
    return 5'd31;
  endfunction

  function automatic logic [31:0] sub_exp(input int ms);
    return 32'((999 - ms) * 128 / 1000);
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic fail_out();
    n_mismatch++;
    finish_test();
  endtask

  // one apb transfer; an idle cycle after it keeps drivers single-assigned
  task automatic apb(input logic wr, input logic [13:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    apb_q.paddr   <= {idx, 2'b00};
    apb_q.pwrite  <= wr;
    apb_q.pwdata  <= wd;
    apb_q.psel    <= 1'b1;
    apb_q.penable <= 1'b0;
    @(posedge clock_i);
    apb_q.penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end
    while (pready_o !== 1'b1 && n < 16);
    if (n >= 16)
      fail_out();
    rd = prdata_o;
    last_err = pslverr_o;
    apb_q.psel    <= 1'b0;
    apb_q.penable <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wr(input logic [13:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    apb(1'b1, idx, wd, d);
  endtask

  task automatic rd(input logic [13:0] idx, output logic [31:0] d);
    apb(1'b0, idx, 32'h0, d);
  endtask

  // calendar writes need the unlock write right before them
  task automatic cal_wr(input logic [13:0] idx, input logic [7:0] v);
    wr(IDX_UNLOCK, 32'h0);
    wr(idx, {24'h0, v});
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    logic [31:0] d;
    logic [16:0] coarse;
    logic [1:0]  fine;
    logic [6:0]  trim;
    int          n;
    apb_q = '0;
    rst_i = 1'b1;
    count_fault_i = 1'b0;
    lfsr_q = 16'h0048;
    n_mismatch = 0;
    tests_run = 0;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    check(32'(osc_trim_o), {25'h0, OSC_TRIM_RST});
    check(32'(freq_adjust_o), 32'h40000);
    rd(IDX_OSC_TRIM, d);
    check(d, 32'h40);
    rd(IDX_ADJ_HI, d);
    check(d, 32'h4);
    rd(IDX_CTRL, d);
    check(d, 32'h0);
    rd(14'h2891, d);
    check({d[31:1], last_err}, 32'h1);
    $display("test reset done");
    // range ends first, then random values inside the legal range
    for (int i = 0; i < 5; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      coarse = (i == 0) ? 17'h0ffbf : (i == 1) ? 17'h10040 : 17'h0ffbf + 17'(lfsr_q % 130);
      fine = lfsr_q[3:2];
      trim = lfsr_q[14:8];
      wr(IDX_ADJ_HI, {29'h0, coarse[16:14]});
      wr(IDX_ADJ_MID, {24'h0, coarse[13:6]});
      wr(IDX_ADJ_LO, {24'h0, coarse[5:0], fine});
      wr(IDX_OSC_TRIM, {25'h0, trim});
      check(32'(freq_adjust_o), {13'h0, coarse, fine});
      check(32'(osc_trim_o), {25'h0, trim});
      rd(IDX_ADJ_LO, d);
      check(d, {24'h0, coarse[5:0], fine});
      rd(IDX_OSC_TRIM, d);
      check(d, {25'h0, trim});
    end
    $display("test adjust done");
    // fault pulse, flag sticky against a write of one, then cleared by zero
    count_fault_i <= 1'b1;
    @(posedge clock_i);
    count_fault_i <= 1'b0;
    rd(IDX_CTRL, d);
    check(d & 32'h10, 32'h10);
    wr(IDX_CTRL, 32'h10);
    rd(IDX_CTRL, d);
    check(d & 32'h10, 32'h10);
    rd(IDX_IRQ_STS, d);
    check(d & 32'h4, 32'h4);
    check(32'(irq_o), 32'h0);
    wr(IDX_IRQ_MASK, 32'h4);
    check(32'(irq_o), 32'h1);
    wr(IDX_IRQ_STS, 32'h4);
    check(32'(irq_o), 32'h0);
    wr(IDX_CTRL, 32'h0);
    rd(IDX_CTRL, d);
    check(d, 32'h0);
    $display("test fault done");
    // load 23:59:58 on a leap february 28th, a saturday
    wr(IDX_ALM_MIN, 32'h0);
    wr(IDX_ALM_HOUR, 32'h0);
    wr(IDX_IRQ_MASK, 32'h1);
    wr(IDX_CTRL, 32'h80);
    rd(IDX_CTRL, d);
    check(d & 32'h80, 32'h80);
    wr(IDX_SEC, 32'h1e);
    rd(IDX_SEC, d);
    check(d, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      cal_wr(fidx[i], fset[i]);
      rd(fidx[i], d);
      check(d, {24'h0, fset[i]});
    end
    wr(IDX_CTRL, 32'h0);
    n = 0;
    do
    begin
      rd(IDX_CTRL, d);
      n++;
    end
    while (d[7] !== 1'b0 && n < 20);
    if (n >= 20)
      fail_out();
    rd(IDX_SUBSEC, d);
    check(d, sub_exp(0));
    $display("test load done");
    // two seconds later time and weekday have rolled over into february 29th
    repeat (20500) @(posedge clock_i);
    wr(IDX_CTRL, 32'h40);
    rd(IDX_CTRL, d);
    check(d, 32'h40);
    fexp = '{8'h0, 8'h0, 8'h0, 8'h1, 8'h0, 8'h2, 8'h4};
    fexp[4] = (5'd28 < month_days(4'd2, 8'd4)) ? 8'd29 : 8'd1;
    for (int i = 0; i < 7; i++)
    begin
      rd(fidx[i], d);
      check(d, {24'h0, fexp[i]});
    end
    check(32'(irq_o), 32'h1);
    rd(IDX_IRQ_STS, d);
    check(d & 32'h1, 32'h1);
    check(d & 32'h2, 32'h2);
    // held shadow ignores a further second, then follows live once released
    repeat (10000) @(posedge clock_i);
    rd(IDX_SEC, d);
    check(d, 32'h0);
    wr(IDX_CTRL, 32'h0);
    rd(IDX_SEC, d);
    check(d, 32'h1);
    wr(IDX_IRQ_STS, 32'h7);
    check(32'(irq_o), 32'h0);
    $display("test calendar done");
    finish_test();
  end
endmodule
